/* src/pfa_defines.svh */
// constants for the port frame admission and flow control block
`ifndef PFA_DEFINES_SVH
`define PFA_DEFINES_SVH
`define PFA_ADDR_CFG 8'h00
`define PFA_ADDR_STORM 8'h04
`define PFA_ADDR_STAT 8'h08
`define PFA_ADDR_CNT 8'h0C
`define PFA_CFG_AGGR_BIT 0
`define PFA_CFG_NODROP_BIT 3
`define PFA_CFG_BP_BIT 5
`define PFA_CFG_LEGAL_BIT 6
`define PFA_CFG_HUGE_BIT 7
`define PFA_CFG_STORM_EN_BIT 8
`define PFA_CFG_MCAST_BIT 9
`define PFA_CFG_SPEED100_BIT 10
`define PFA_CFG_FDX_BIT 11
`define PFA_MIN_LEN 16'd64
`define PFA_STD_MAX_LEN 16'd1518
`define PFA_LEGAL_MAX_LEN 16'd1536
`define PFA_HUGE_MAX_LEN 16'd1916
`define PFA_VLAN_TAG_LEN 16'd4
`define PFA_STORM_RESET 16'h004A
`define PFA_CLK_MHZ 125
`define PFA_IVL_100_MS 50
`define PFA_IVL_10_MS 500
`define PFA_IVL_100_CYC (`PFA_IVL_100_MS * 1000 * `PFA_CLK_MHZ)
`define PFA_IVL_10_CYC (`PFA_IVL_10_MS * 1000 * `PFA_CLK_MHZ)
`define PFA_PAUSE_MAX 16'hFFFF
`define PFA_PAUSE_ZERO 16'h0000
`define PFA_QUANTUM_CYC 8'd64
`endif

/* src/pfa_pkg.sv */
// types for the port frame admission and flow control block
package pfa_pkg;
	typedef struct packed {
		logic [15:0] len;
		logic vlan;
		logic bcast;
		logic mcast;
		logic pause;
		logic [15:0] pause_time;
		logic err;
		logic local_dst;
	} pfa_rx_info_s;
	typedef enum logic [1:0] {
		PFA_FC_IDLE,
		PFA_FC_XOFF_WAIT,
		PFA_FC_ON,
		PFA_FC_XON_WAIT
	} pfa_fc_e;
	typedef enum logic [1:0] {
		PFA_BP_IDLE,
		PFA_BP_CARRIER,
		PFA_BP_SILENT,
		PFA_BP_YIELD
	} pfa_bp_e;
endpackage

/* src/pfa_top.sv */
// frame admission, pause, back pressure and storm control for one switch port
`timescale 1ns/1ps
`default_nettype none
`include "pfa_defines.svh"
// Functional notes
// [R1] drop frames shorter than 64 bytes
// [R2] option: accept frames up to 1536 bytes
// [R3] option: accept frames up to 1916 bytes
// [R4] vlan tagged frames get larger maximum
// [R5] received pause holds normal transmit until expiry
// [R6] newer pause frame reloads the timer
// [R7] while paused only own pause frames go
// [R8] busy destination triggers xoff with maximum time
// [R9] freed resource triggers xon with zero time
// [R10] hysteresis between assert and release thresholds
// [R11] full receive queue flow controls every port
// [R12] errored or illegal size frames never forwarded
// [R13] pause frames consumed, never forwarded
// [R14] frames to own port dropped
// [R15] half duplex back pressure sends preamble carrier
// [R16] release carrier briefly after hold limit
// [R17] yield carrier to queued frames then resume
// [R18] collision in back pressure regenerates carrier now
// [R19] aggressive, nodrop, back pressure bits default off
// [R20] global storm rate, per port enable, multicast option
// [R21] storm counter cleared each 50/500 ms interval
// [R22] storm rate resets to 0x4A
// [R23] storm frames over limit dropped until interval
module pfa_top import pfa_pkg::*; #(
	parameter int IVL_100_CYC = `PFA_IVL_100_CYC,
	parameter int IVL_10_CYC = `PFA_IVL_10_CYC,
	parameter int BP_HOLD_CYC = 8192,
	parameter int BP_SILENT_CYC = 8,
	parameter int BUF_HI = 448,
	parameter int BUF_LO = 384
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// received frame verdict
	input wire logic rx_done_i,
	input wire pfa_rx_info_s rx_info_i,
	output logic fwd_o,
	output logic drop_o,
	// switch resource status
	input wire logic dst_busy_i,
	input wire logic rxq_full_i,
	input wire logic [9:0] buf_used_i,
	// transmit side
	input wire logic tx_pending_i,
	input wire logic tx_frame_busy_i,
	input wire logic col_i,
	output logic tx_normal_ok_o,
	output logic pause_req_o,
	output logic [15:0] pause_time_o,
	input wire logic pause_ack_i,
	output logic bp_carrier_o,
	output logic aggr_backoff_o,
	output logic nodrop_excol_o
);
	logic [31:0] cfg;
	logic [15:0] storm_rate;
	logic [15:0] storm_cnt;
	logic [31:0] ivl_cnt;
	logic [15:0] pause_tmr;
	logic [7:0] quanta_cnt;
	logic [31:0] bp_cnt;
	logic congested;
	logic paused;
	logic [15:0] max_len;
	logic size_bad;
	logic storm_hit;
	logic is_storm;
	logic aw_hold, w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	pfa_fc_e fc_st;
	pfa_bp_e bp_st;

	// resource thresholds with hysteresis; queue full forces every port
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			congested <= 1'b0;
		end else if (ce_i) begin
			if (rxq_full_i || dst_busy_i || buf_used_i >= 10'(BUF_HI)) begin // [R10] [R11]
				congested <= 1'b1;
			end else if (buf_used_i < 10'(BUF_LO)) begin // [R10]
				congested <= 1'b0;
			end
		end
	end

	// write channel: address and data taken in either order
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= 2'b00;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (aw_hold && w_hold && !s_axi_bvalid_o) begin
				s_axi_bvalid_o <= 1'b1;
				if (aw_addr == `PFA_ADDR_CFG || aw_addr == `PFA_ADDR_STORM) begin
					s_axi_bresp_o <= 2'b00;
				end else if (aw_addr == `PFA_ADDR_STAT || aw_addr == `PFA_ADDR_CNT) begin
					s_axi_bresp_o <= 2'b00;
				end else begin
					s_axi_bresp_o <= 2'b10;
				end
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// configuration registers, committed once per write
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cfg <= 32'h0000_0000; // [R19]
			storm_rate <= `PFA_STORM_RESET; // [R22]
		end else if (ce_i && aw_hold && w_hold && !s_axi_bvalid_o) begin
			if (aw_addr == `PFA_ADDR_CFG) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb[b]) begin
						cfg[b*8 +: 8] <= w_data[b*8 +: 8];
					end
				end
			end else if (aw_addr == `PFA_ADDR_STORM) begin
				for (int b = 0; b < 2; b++) begin
					if (w_strb[b]) begin
						storm_rate[b*8 +: 8] <= w_data[b*8 +: 8]; // [R20]
					end
				end
			end
		end
	end

	// read channel
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= 2'b00;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o <= 2'b00;
				if (s_axi_araddr_i == `PFA_ADDR_CFG) begin
					s_axi_rdata_o <= {20'h00000, cfg[11:0]};
				end else if (s_axi_araddr_i == `PFA_ADDR_STORM) begin
					s_axi_rdata_o <= {16'h0000, storm_rate};
				end else if (s_axi_araddr_i == `PFA_ADDR_STAT) begin
					s_axi_rdata_o <= {pause_tmr, 11'h000, bp_carrier_o, congested, paused, fc_st};
				end else if (s_axi_araddr_i == `PFA_ADDR_CNT) begin
					s_axi_rdata_o <= {16'h0000, storm_cnt};
				end else begin
					s_axi_rdata_o <= 32'h0000_0000;
					s_axi_rresp_o <= 2'b10;
				end
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// size limits
	always_comb begin
		if (cfg[`PFA_CFG_HUGE_BIT]) begin
			max_len = `PFA_HUGE_MAX_LEN; // [R3]
		end else if (cfg[`PFA_CFG_LEGAL_BIT]) begin
			max_len = `PFA_LEGAL_MAX_LEN; // [R2]
		end else begin
			max_len = `PFA_STD_MAX_LEN;
		end
		if (rx_info_i.vlan) begin
			max_len = max_len + `PFA_VLAN_TAG_LEN; // [R4]
		end
		size_bad = (rx_info_i.len < `PFA_MIN_LEN) || (rx_info_i.len > max_len); // [R1]
	end

	assign is_storm = rx_info_i.bcast || (cfg[`PFA_CFG_MCAST_BIT] && rx_info_i.mcast); // [R20]
	assign storm_hit = cfg[`PFA_CFG_STORM_EN_BIT] && is_storm && (storm_cnt >= storm_rate); // [R23]

	// frame verdict, one pulse per finished frame
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fwd_o <= 1'b0;
			drop_o <= 1'b0;
		end else if (ce_i) begin
			fwd_o <= 1'b0;
			drop_o <= 1'b0;
			if (rx_done_i) begin
				if (size_bad || rx_info_i.err || rx_info_i.pause || rx_info_i.local_dst || storm_hit) begin
					drop_o <= 1'b1; // [R12] [R13] [R14] [R23]
				end else begin
					fwd_o <= 1'b1;
				end
			end
		end
	end

	// storm interval and counter; a frame in the clearing cycle starts the new count
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ivl_cnt <= 32'd0;
			storm_cnt <= 16'h0000;
		end else if (ce_i) begin
			if (ivl_cnt >= 32'(cfg[`PFA_CFG_SPEED100_BIT] ? IVL_100_CYC - 1 : IVL_10_CYC - 1)) begin // [R21]
				ivl_cnt <= 32'd0;
				storm_cnt <= (rx_done_i && is_storm) ? 16'h0001 : 16'h0000; // [R21]
			end else begin
				ivl_cnt <= ivl_cnt + 32'd1;
				if (rx_done_i && is_storm && storm_cnt != 16'hFFFF) begin
					storm_cnt <= storm_cnt + 16'h0001; // [R21]
				end
			end
		end
	end

	// received pause timer in 512-bit quanta
	assign paused = (pause_tmr != 16'h0000);
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pause_tmr <= 16'h0000;
			quanta_cnt <= 8'd0;
		end else if (ce_i) begin
			if (rx_done_i && rx_info_i.pause && !rx_info_i.err && cfg[`PFA_CFG_FDX_BIT]) begin
				pause_tmr <= rx_info_i.pause_time; // [R5] [R6] [R13]
				quanta_cnt <= 8'd0;
			end else if (paused) begin
				if (quanta_cnt == `PFA_QUANTUM_CYC - 8'd1) begin
					quanta_cnt <= 8'd0;
					pause_tmr <= pause_tmr - 16'h0001; // [R5]
				end else begin
					quanta_cnt <= quanta_cnt + 8'd1;
				end
			end
		end
	end

	// a frame already on the wire finishes; only the next one waits
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_normal_ok_o <= 1'b0;
		end else if (ce_i) begin
			tx_normal_ok_o <= !paused && !(bp_st == PFA_BP_CARRIER || bp_st == PFA_BP_SILENT); // [R5] [R7]
		end
	end

	// xoff/xon generation in full duplex
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fc_st <= PFA_FC_IDLE;
			pause_req_o <= 1'b0;
			pause_time_o <= `PFA_PAUSE_ZERO;
		end else if (ce_i) begin
			case (fc_st)
				PFA_FC_IDLE: begin
					if (congested && cfg[`PFA_CFG_FDX_BIT]) begin
						fc_st <= PFA_FC_XOFF_WAIT;
						pause_req_o <= 1'b1; // [R7] [R8]
						pause_time_o <= `PFA_PAUSE_MAX; // [R8]
					end
				end
				PFA_FC_XOFF_WAIT: begin
					if (pause_ack_i) begin
						pause_req_o <= 1'b0;
						fc_st <= PFA_FC_ON;
					end
				end
				PFA_FC_ON: begin
					if (!congested) begin
						fc_st <= PFA_FC_XON_WAIT;
						pause_req_o <= 1'b1;
						pause_time_o <= `PFA_PAUSE_ZERO; // [R9]
					end
				end
				PFA_FC_XON_WAIT: begin
					if (pause_ack_i) begin
						pause_req_o <= 1'b0;
						fc_st <= PFA_FC_IDLE;
					end
				end
				default: fc_st <= PFA_FC_IDLE;
			endcase
		end
	end

	// half duplex back pressure by carrier
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bp_st <= PFA_BP_IDLE;
			bp_cnt <= 32'd0;
			bp_carrier_o <= 1'b0;
		end else if (ce_i) begin
			case (bp_st)
				PFA_BP_IDLE: begin
					bp_carrier_o <= 1'b0;
					if (congested && cfg[`PFA_CFG_BP_BIT] && !cfg[`PFA_CFG_FDX_BIT] && !tx_frame_busy_i) begin // [R15]
						bp_st <= PFA_BP_CARRIER;
						bp_cnt <= 32'd0;
						bp_carrier_o <= 1'b1; // [R15]
					end
				end
				PFA_BP_CARRIER: begin
					if (!congested || !cfg[`PFA_CFG_BP_BIT] || cfg[`PFA_CFG_FDX_BIT]) begin
						bp_st <= PFA_BP_IDLE;
						bp_carrier_o <= 1'b0;
					end else if (tx_pending_i) begin
						bp_st <= PFA_BP_YIELD; // [R17]
						bp_carrier_o <= 1'b0;
					end else if (col_i) begin
						bp_cnt <= 32'd0; // [R18]
						bp_carrier_o <= 1'b1; // [R18]
					end else if (bp_cnt >= 32'(BP_HOLD_CYC - 1)) begin
						bp_st <= PFA_BP_SILENT; // [R16]
						bp_cnt <= 32'd0;
						bp_carrier_o <= 1'b0;
					end else begin
						bp_cnt <= bp_cnt + 32'd1;
					end
				end
				PFA_BP_SILENT: begin
					if (bp_cnt >= 32'(BP_SILENT_CYC - 1) || col_i) begin
						bp_st <= PFA_BP_CARRIER; // [R16] [R18]
						bp_cnt <= 32'd0;
						bp_carrier_o <= 1'b1;
					end else begin
						bp_cnt <= bp_cnt + 32'd1;
					end
				end
				PFA_BP_YIELD: begin
					bp_carrier_o <= 1'b0;
					if (!tx_pending_i && !tx_frame_busy_i) begin
						bp_st <= PFA_BP_IDLE; // [R17]
					end
				end
				default: bp_st <= PFA_BP_IDLE;
			endcase
		end
	end

	// mac back-off options
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			aggr_backoff_o <= 1'b0;
			nodrop_excol_o <= 1'b0;
		end else if (ce_i) begin
			aggr_backoff_o <= cfg[`PFA_CFG_AGGR_BIT]; // [R19]
			nodrop_excol_o <= cfg[`PFA_CFG_NODROP_BIT]; // [R19]
		end
	end
endmodule
`default_nettype wire

/* tb/pfa_chk.sv */
// assertions on frame verdicts and pause requests
`timescale 1ns/1ps
`default_nettype none
module pfa_chk import pfa_pkg::*; #(
	parameter int BUF_LO = 384
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// frame verdict
	input wire logic rx_done_i,
	input wire pfa_rx_info_s rx_info_i,
	input wire logic fwd_o,
	input wire logic drop_o,
	// flow control
	input wire logic dst_busy_i,
	input wire logic rxq_full_i,
	input wire logic [9:0] buf_used_i,
	input wire logic pause_req_o,
	input wire logic [15:0] pause_time_o,
	input wire logic pause_ack_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic calm;
	assign calm = !dst_busy_i && !rxq_full_i && buf_used_i < 10'(BUF_LO);
	sequence s_xoff;
		pause_req_o && pause_time_o == 16'hFFFF;
	endsequence
	sequence s_xon;
		pause_req_o && pause_time_o == 16'h0000;
	endsequence
	AST_ONE_VERDICT: assert property (rx_done_i |=> fwd_o != drop_o) else $error("verdict count");
	AST_RUNT: assert property (rx_done_i && rx_info_i.len < 16'h0040 |=> drop_o) else $error("runt passed");
	AST_ERRORED: assert property (rx_done_i && rx_info_i.err |=> drop_o) else $error("bad frame passed");
	AST_PAUSE_EATEN: assert property (rx_done_i && rx_info_i.pause |=> drop_o) else $error("pause passed");
	AST_LOCAL: assert property (rx_done_i && rx_info_i.local_dst |=> drop_o) else $error("local passed");
	// eight calm cycles first, so no earlier request is still waiting
	AST_XOFF: assert property (calm [*8] ##1 dst_busy_i |-> ##[1:4] s_xoff) else $error("no xoff");
	AST_XON: assert property (dst_busy_i [*8] ##1 calm |-> ##[1:6] s_xon) else $error("no xon");
	AST_REQ_HELD: assert property (pause_req_o && !pause_ack_i |=> pause_req_o && $stable(pause_time_o))
		else $error("request not held");
endmodule
bind pfa_top pfa_chk #(.BUF_LO(BUF_LO)) u_chk (.clk_sys_i, .rst_i, .rx_done_i, .rx_info_i, .fwd_o, .drop_o,
	.dst_busy_i, .rxq_full_i, .buf_used_i, .pause_req_o, .pause_time_o, .pause_ack_i);
`default_nettype wire

/* tb/pfa_partner.sv */
// link partner model: received frames, collisions and pause acknowledges
`timescale 1ns/1ps
`default_nettype none
module pfa_partner import pfa_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// pause handshake
	input wire logic pause_req_i,
	input wire logic [1:0] ack_dly_i,
	output logic pause_ack_o,
	// receive and line events
	output logic rx_done_o,
	output pfa_rx_info_s rx_info_o,
	output logic col_o
);
	logic [1:0] wait_cnt;
	initial begin
		pause_ack_o = 1'h0;
		rx_done_o = 1'h0;
		rx_info_o = '0;
		col_o = 1'h0;
	end
	always @(posedge clk_sys_i) begin
		if (rst_i || !pause_req_i || pause_ack_o) begin
			wait_cnt <= 2'h0;
			pause_ack_o <= 1'h0;
		end else if (wait_cnt == ack_dly_i) begin
			pause_ack_o <= 1'h1;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
	task send(input pfa_rx_info_s f);
		@(posedge clk_sys_i);
		rx_done_o <= 1'h1;
		rx_info_o <= f;
		@(posedge clk_sys_i);
		rx_done_o <= 1'h0;
		// stale info is inverted so it never looks valid by accident
		rx_info_o <= ~f;
	endtask
	task collide;
		@(posedge clk_sys_i);
		col_o <= 1'h1;
		@(posedge clk_sys_i);
		col_o <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the port admission and flow control block
`timescale 1ns/1ps
`default_nettype none
module tb_top import pfa_pkg::*;;
	localparam int IVL = 600;
	localparam int HOLD = 64;
	logic clk_sys_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs, ack_dly = 2'h0;
	logic rx_done_i, fwd_o, drop_o, col_i, pause_ack_i;
	logic dst_busy_i = 1'h0, rxq_full_i = 1'h0, tx_pending_i = 1'h0, tx_frame_busy_i = 1'h0;
	pfa_rx_info_s rx_info_i;
	logic [9:0] buf_used_i = 10'h0;
	logic tx_normal_ok_o, pause_req_o, bp_carrier_o, aggr_backoff_o, nodrop_excol_o;
	logic [15:0] pause_time_o;
	int n_mismatch = 0, comparisons = 0, n;
	always #4 clk_sys_i = ~clk_sys_i;
	pfa_top #(.IVL_100_CYC(IVL), .IVL_10_CYC(2000), .BP_HOLD_CYC(HOLD)) dut (.clk_sys_i, .rst_i, .ce_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
		.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rx_done_i,
		.rx_info_i, .fwd_o, .drop_o, .dst_busy_i, .rxq_full_i, .buf_used_i, .tx_pending_i, .tx_frame_busy_i,
		.col_i, .tx_normal_ok_o, .pause_req_o, .pause_time_o, .pause_ack_i, .bp_carrier_o, .aggr_backoff_o,
		.nodrop_excol_o);
	pfa_partner lp (.clk_sys_i, .rst_i, .pause_req_i(pause_req_o), .ack_dly_i(ack_dly),
		.pause_ack_o(pause_ack_i), .rx_done_o(rx_done_i), .rx_info_o(rx_info_i), .col_o(col_i));
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task test_done;
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task lost;
		chk("wait bound", 1, 0);
		test_done;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wdata_i <= d;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		repeat (50) begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
			if (s_axi_bvalid_o) begin
				s_axi_bready_i <= 1'h0;
				rs = s_axi_bresp_o;
				return;
			end
		end
		lost;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		repeat (50) begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
			if (s_axi_rvalid_o) begin
				s_axi_rready_i <= 1'h0;
				rd = s_axi_rdata_o;
				rs = s_axi_rresp_o;
				return;
			end
		end
		lost;
	endtask
	// flags: vlan, bcast, mcast, pause, err, local
	task frm(input logic [15:0] len, input logic [5:0] f, input logic [15:0] pt, input logic ok);
		pfa_rx_info_s i;
		i = '0;
		i.len = len;
		i.pause_time = pt;
		{i.vlan, i.bcast, i.mcast, i.pause, i.err, i.local_dst} = f;
		lp.send(i);
		#1 chk("fwd", ok, fwd_o);
		chk("drop", !ok, drop_o);
	endtask
	task till(input int sel, input logic lvl, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge clk_sys_i);
			#1;
			if ((sel == 0 ? tx_normal_ok_o : sel == 1 ? pause_req_o : bp_carrier_o) === lvl) return;
		end
		lost;
	endtask
	task pz(input logic [15:0] t);
		till(1, 1'h1, 12);
		chk("pause time", t, pause_time_o);
		till(1, 1'h0, 12);
	endtask
	task t_regs;
		rdr(8'h00);
		chk("cfg reset", 0, rd);
		chk("aggr", 0, {aggr_backoff_o, nodrop_excol_o});
		rdr(8'h04);
		chk("storm rate", 32'h4A, rd);
		rdr(8'h10);
		chk("rresp", 2'h2, rs);
		wr(8'h10, 32'hFFF);
		chk("bresp", 2'h2, rs);
		rdr(8'h00);
		chk("cfg kept", 0, rd);
	endtask
	task t_size;
		frm(16'h003F, 6'h00, 16'h0, 1'h0);
		frm(16'h0040, 6'h00, 16'h0, 1'h1);
		frm(16'h05EE, 6'h00, 16'h0, 1'h1);
		frm(16'h05EF, 6'h00, 16'h0, 1'h0);
		frm(16'h05F2, 6'h20, 16'h0, 1'h1);
		frm(16'h05F3, 6'h20, 16'h0, 1'h0);
		for (int k = 0; k < 3; k++) frm(16'h0064, 6'h01 << k, 16'h0, 1'h0);
		wr(8'h00, 32'h040);
		frm(16'h0600, 6'h00, 16'h0, 1'h1);
		frm(16'h0601, 6'h00, 16'h0, 1'h0);
		frm(16'h0604, 6'h20, 16'h0, 1'h1);
		wr(8'h00, 32'h0C0);
		frm(16'h077C, 6'h00, 16'h0, 1'h1);
		frm(16'h077D, 6'h00, 16'h0, 1'h0);
	endtask
	task t_pause;
		wr(8'h00, 32'h800);
		frm(16'h0064, 6'h04, 16'h0001, 1'h0);
		till(0, 1'h0, 4);
		repeat (20) @(posedge clk_sys_i);
		frm(16'h0064, 6'h04, 16'h0003, 1'h0);
		@(posedge clk_sys_i);
		dst_busy_i <= 1'h1;
		pz(16'hFFFF);
		chk("paused", 0, tx_normal_ok_o);
		repeat (8) @(posedge clk_sys_i);
		dst_busy_i <= 1'h0;
		pz(16'h0000);
		repeat (60) @(posedge clk_sys_i);
		#1 chk("reloaded", 0, tx_normal_ok_o);
		till(0, 1'h1, 200);
		chk("late resume", 1, n >= 20);
	endtask
	task t_hyst;
		ack_dly <= 2'h2;
		@(posedge clk_sys_i);
		buf_used_i <= 10'd448;
		pz(16'hFFFF);
		@(posedge clk_sys_i);
		buf_used_i <= 10'd400;
		repeat (20) @(posedge clk_sys_i);
		#1 chk("in band", 0, pause_req_o);
		rdr(8'h08);
		chk("congested", 1, rd[3]);
		@(posedge clk_sys_i);
		buf_used_i <= 10'd383;
		pz(16'h0000);
		@(posedge clk_sys_i);
		rxq_full_i <= 1'h1;
		pz(16'hFFFF);
		@(posedge clk_sys_i);
		rxq_full_i <= 1'h0;
		pz(16'h0000);
	endtask
	task t_bp;
		wr(8'h00, 32'h029);
		#1 chk("lossless bits", 2'h3, {aggr_backoff_o, nodrop_excol_o});
		chk("idle carrier", 0, bp_carrier_o);
		// buffer level congests here: a busy destination in half duplex must not look like a missing xoff
		@(posedge clk_sys_i);
		buf_used_i <= 10'd448;
		till(2, 1'h1, 10);
		till(2, 1'h0, HOLD + 10);
		chk("hold", 1, n >= HOLD - 10);
		till(2, 1'h1, 12);
		repeat (40) @(posedge clk_sys_i);
		lp.collide;
		till(2, 1'h0, HOLD + 10);
		chk("hold after collision", 1, n >= HOLD - 8);
		till(2, 1'h1, 12);
		@(posedge clk_sys_i);
		tx_pending_i <= 1'h1;
		till(2, 1'h0, 6);
		repeat (10) @(posedge clk_sys_i);
		#1 chk("yield", 0, bp_carrier_o);
		@(posedge clk_sys_i);
		tx_pending_i <= 1'h0;
		tx_frame_busy_i <= 1'h1;
		repeat (4) @(posedge clk_sys_i);
		#1 chk("busy wire", 0, bp_carrier_o);
		@(posedge clk_sys_i);
		tx_frame_busy_i <= 1'h0;
		till(2, 1'h1, 10);
		@(posedge clk_sys_i);
		buf_used_i <= 10'd0;
		till(2, 1'h0, 10);
	endtask
	task t_storm;
		// mid-run reset restarts the interval counter, so the frames below sit at a known distance from the wrap
		@(posedge clk_sys_i);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		#1 chk("normal after reset", 0, tx_normal_ok_o);
		rdr(8'h00);
		chk("cfg after reset", 0, rd);
		chk("lossless reset", 0, {aggr_backoff_o, nodrop_excol_o});
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h500);
		frm(16'h0064, 6'h10, 16'h0, 1'h1);
		frm(16'h0064, 6'h10, 16'h0, 1'h1);
		frm(16'h0064, 6'h10, 16'h0, 1'h0);
		frm(16'h0064, 6'h08, 16'h0, 1'h1);
		wr(8'h00, 32'h700);
		frm(16'h0064, 6'h08, 16'h0, 1'h0);
		rdr(8'h0C);
		chk("storm count", 4, rd);
		repeat (IVL) @(posedge clk_sys_i);
		frm(16'h0064, 6'h10, 16'h0, 1'h1);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		t_regs;
		t_size;
		t_pause;
		t_hyst;
		t_bp;
		t_storm;
		test_done;
	end
endmodule
`default_nettype wire
